// ---- hw/blit_rop_mode_control.sv ----
// Blit engine control: start/status, logic function, mode extensions, key compare.
// Assumes index port, pixel stream and colour inputs all on clk_in.
`timescale 1ns/10ps
`include "blit_consts.svh"

module blit_rop_mode_control (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [7:0]       reg_index_in,
    input  wire logic             reg_wr_in,
    input  wire logic [7:0]       reg_wdata_in,
    output logic      [7:0]       reg_rdata_out,
    input  wire logic [7:0]       dbuf_ctrl_in,
    input  wire logic [23:0]      screen_start_in,
    input  wire logic             mem_cycle_free_in,
    input  wire logic [15:0]      fg_color_in,
    input  wire logic [15:0]      bg_color_in,
    input  wire blit_pkg::pix_in_t pix_in,
    input  wire logic             pix_valid_in,
    output logic                  pix_ready_out,
    output blit_pkg::pix_out_t    pix_out,
    output logic [5:0]            discard_bits_out,
    output logic                  discard_valid_out,
    output logic [23:0]           display_start_out,
    output logic                  busy_out
);
    import blit_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0]  mode_reg;
    logic [7:0]  rop_reg;
    logic [7:0]  ext_reg;
    logic [7:0]  key_lo_reg;
    logic [7:0]  key_hi_reg;
    logic [2:0]  status_ctl_reg;
    logic        launch_reg;
    logic        disp_sel_reg;
    eng_state_t  state_reg;
    pix_out_t    pix_out_reg;
    logic [5:0]  discard_reg;
    logic        discard_valid_reg;
    logic [7:0]  rdata_reg;

    logic wr_mode, wr_rop, wr_ext, wr_klo, wr_khi, wr_start;
    logic abort_req, take_pix, finish;

    assign wr_mode  = reg_wr_in && reg_index_in == `IDX_MODE;
    assign wr_rop   = reg_wr_in && reg_index_in == `IDX_ROP;
    assign wr_ext   = reg_wr_in && reg_index_in == `IDX_MODE_EXT;
    assign wr_klo   = reg_wr_in && reg_index_in == `IDX_KEY_LOW;
    assign wr_khi   = reg_wr_in && reg_index_in == `IDX_KEY_HIGH;
    assign wr_start = reg_wr_in && reg_index_in == `IDX_START;
    assign abort_req = wr_start && reg_wdata_in[`ST_ABORT];
    assign take_pix  = pix_valid_in && state_reg == ENG_RUN;
    assign finish    = take_pix && pix_in.last;

    // ==========================================================
    // Logic function table
    // one code per logic, operand chosen upstream
    function automatic logic [15:0] apply_lf(input logic [7:0] code,
                                             input logic [15:0] s,
                                             input logic [15:0] d);
        case (code)
            `LF_ZERO:   apply_lf = 16'h0000;
            `LF_NOR:    apply_lf = ~(s | d);
            `LF_NSA_D:  apply_lf = ~s & d;
            `LF_NS:     apply_lf = ~s;
            `LF_S_ND:   apply_lf = s & ~d;
            `LF_ND:     apply_lf = ~d;
            `LF_XOR:    apply_lf = s ^ d;
            `LF_NAND:   apply_lf = ~(s & d);
            `LF_AND:    apply_lf = s & d;
            `LF_XNOR:   apply_lf = ~(s ^ d);
            `LF_D:      apply_lf = d;
            `LF_NS_O_D: apply_lf = ~s | d;
            `LF_S:      apply_lf = s;
            `LF_S_O_ND: apply_lf = s | ~d;
            `LF_OR:     apply_lf = s | d;
            `LF_ONE:    apply_lf = 16'hFFFF;
            // Unlisted codes leave the destination untouched
            default:    apply_lf = d;
        endcase
    endfunction : apply_lf

    // bits to drop at line end
    function automatic logic [5:0] discard_count(input logic to_dword,
                                                 input logic [4:0] pos);
        if (to_dword) begin
            discard_count = (`DWORD_BITS - {1'b0, pos}) & `DWORD_MASK;
        end else begin
            discard_count = {3'h0, 3'(3'h0 - pos[2:0])};
        end
    endfunction : discard_count

    // ==========================================================
    // Register writes
    always_ff @(posedge clk_in) begin
        if (rst_in || abort_req) begin
            mode_reg   <= `REG_RESET;
            rop_reg    <= `REG_RESET;
            key_lo_reg <= `REG_RESET;
            key_hi_reg <= `REG_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= reg_wdata_in;
            end
            if (wr_rop) begin
                rop_reg <= reg_wdata_in;
            end
            if (wr_klo) begin
                key_lo_reg <= reg_wdata_in;
            end
            if (wr_khi) begin
                key_hi_reg <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_reg <= `REG_RESET;
        end else if (wr_ext && status_ctl_reg[2] && dbuf_ctrl_in[`DBUF_EXT_WEN]) begin
            ext_reg <= {3'h0, reg_wdata_in[4:0]};
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_ctl_reg <= 3'h0;
        end else if (wr_start) begin
            status_ctl_reg <= reg_wdata_in[`ST_AUTOSTART:`ST_PAUSE];
        end
    end

    // ==========================================================
    // Engine sequencing
    // abort wins over launch and finish
    always_ff @(posedge clk_in) begin
        if (rst_in || abort_req) begin
            launch_reg <= 1'b0;
        end else if (wr_start && reg_wdata_in[`ST_LAUNCH]) begin
            launch_reg <= 1'b1;
        end else if (finish) begin
            launch_reg <= 1'b0;
        end
    end

    // busy from launch to last pixel
    always_ff @(posedge clk_in) begin
        if (rst_in || abort_req) begin
            state_reg <= ENG_IDLE;
        end else begin
            case (state_reg)
                ENG_IDLE: begin
                    if (launch_reg && mem_cycle_free_in) begin
                        state_reg <= ENG_RUN;
                    end
                end
                ENG_RUN: begin
                    if (finish) begin
                        state_reg <= ENG_IDLE;
                    end
                end
                default: state_reg <= ENG_IDLE;
            endcase
        end
    end

    // buffer swap at end of transfer
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            disp_sel_reg <= 1'b0;
        end else if (finish && ext_reg[`EXT_SYNC_SWITCH]
                     && dbuf_ctrl_in[`DBUF_SEL_HI:0] == `DBUF_SEL_ALL) begin
            disp_sel_reg <= ~disp_sel_reg;
        end
    end

    // ==========================================================
    // Pixel path
    logic        expand, solid, transp, mono_eff, is_bg, skip, clipped;
    logic [15:0] operand, result, key;

    always_comb begin
        expand   = mode_reg[`MODE_EXPAND];
        solid    = ext_reg[`EXT_SOLID];
        transp   = mode_reg[`MODE_TRANSP];
        // solid fill acts as all-ones bitmap unless invert and transparency are both set
        mono_eff = pix_in.mono | solid;
        if (ext_reg[`EXT_INVERT] && transp) begin
            mono_eff = ~pix_in.mono;
        end
        is_bg = ~mono_eff;
        if (expand) begin
            operand = mono_eff ? fg_color_in : bg_color_in;
        end else if (mode_reg[`MODE_PATTERN]) begin
            operand = pix_in.pat;
        end else begin
            operand = pix_in.src;
        end
        result = apply_lf(rop_reg, operand, pix_in.dst);
        key = {key_hi_reg, key_lo_reg};
        skip = 1'b0;
        if (expand && transp && is_bg) begin
            skip = 1'b1;
        end else if (!expand && transp) begin
            // key compare on full pixel width
            if (mode_reg[`MODE_WIDTH_HI:`MODE_WIDTH_LO] == `WIDTH_8BPP) begin
                skip = result[7:0] == key[7:0];
            end else begin
                skip = result == key;
            end
        end
        if (expand && ext_reg[`EXT_BG_CLIP]) begin
            clipped = pix_in.clip && is_bg;
        end else begin
            clipped = pix_in.clip;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || abort_req) begin
            pix_out_reg <= '0;
        end else begin
            pix_out_reg.valid <= take_pix;
            pix_out_reg.write <= take_pix && !skip && !clipped;
            pix_out_reg.data  <= result;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || abort_req) begin
            discard_reg       <= 6'h00;
            discard_valid_reg <= 1'b0;
        end else begin
            discard_valid_reg <= take_pix && pix_in.line_end && mode_reg[`MODE_SYS_SRC];
            discard_reg <= discard_count(!mode_reg[`MODE_EXPAND] || ext_reg[`EXT_GRAN],
                                         pix_in.line_bit_pos);
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_reg <= `REG_RESET;
        end else begin
            case (reg_index_in)
                `IDX_MODE:     rdata_reg <= mode_reg;
                `IDX_ROP:      rdata_reg <= rop_reg;
                `IDX_MODE_EXT: rdata_reg <= ext_reg;
                `IDX_KEY_LOW:  rdata_reg <= key_lo_reg;
                `IDX_KEY_HIGH: rdata_reg <= key_hi_reg;
                `IDX_START:    rdata_reg <= {status_ctl_reg, 3'h0, launch_reg,
                                             state_reg == ENG_RUN};
                default:       rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out     = rdata_reg;
    assign pix_ready_out     = state_reg == ENG_RUN;
    assign pix_out           = pix_out_reg;
    assign discard_bits_out  = discard_reg;
    assign discard_valid_out = discard_valid_reg;
    assign display_start_out = disp_sel_reg ? screen_start_in : 24'h000000;
    assign busy_out          = state_reg == ENG_RUN;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    abort_clears_busy_a: assert property (abort_req |=> !busy_out && !launch_reg)
        else $error("abort did not idle engine");
    launch_starts_a: assert property (!busy_out && launch_reg && mem_cycle_free_in
                                      && !abort_req |=> busy_out)
        else $error("launch not taken on free cycle");
    finish_clears_a: assert property (finish && !abort_req |=> !launch_reg && !busy_out)
        else $error("launch bit not cleared at finish");
    busy_readback_a: assert property (reg_index_in == `IDX_START && !abort_req
                                      |=> reg_rdata_out[`ST_BUSY] == $past(busy_out))
        else $error("busy readback wrong");
    ext_gate_a: assert property (wr_ext && !(status_ctl_reg[2] && dbuf_ctrl_in[`DBUF_EXT_WEN])
                                 |=> $stable(ext_reg))
        else $error("mode extension write not blocked");
    swap_a: assert property (finish && ext_reg[`EXT_SYNC_SWITCH]
                             && dbuf_ctrl_in[`DBUF_SEL_HI:0] == `DBUF_SEL_ALL
                             |=> disp_sel_reg != $past(disp_sel_reg))
        else $error("display buffer not swapped");
    fill_ones_a: assert property (take_pix && !abort_req && rop_reg == `LF_ONE
                                  |=> pix_out.data == 16'hFFFF)
        else $error("ones function wrong");
    solid_fg_a: assert property (take_pix && !abort_req && solid && expand
                                 && rop_reg == `LF_S && !ext_reg[`EXT_INVERT]
                                 |=> pix_out.data == $past(fg_color_in))
        else $error("solid fill not foreground");
    key_skip_a: assert property (take_pix && !abort_req && !expand && transp
                                 && result == key |=> !pix_out.write)
        else $error("key match written");
    transp_bg_a: assert property (take_pix && !abort_req && expand && transp
                                  && is_bg |=> !pix_out.write)
        else $error("transparent background written");

    cover_transfer_c: cover property (busy_out ##[1:20] !busy_out);
    cover_abort_c: cover property (busy_out && abort_req);
    cover_swap_c: cover property (finish && ext_reg[`EXT_SYNC_SWITCH]);

endmodule : blit_rop_mode_control

// ---- pkg/blit_consts.svh ----
// Offsets, field positions, codes and reset values of the blit control block.
// Assumes inclusion by bare name from the design file.
`ifndef BLIT_CONSTS_SVH
`define BLIT_CONSTS_SVH

// ==========================================================
// Register offsets on the index port
`define IDX_MODE        8'h18
`define IDX_ROP         8'h1A
`define IDX_MODE_EXT    8'h1B
`define IDX_KEY_LOW     8'h1C
`define IDX_KEY_HIGH    8'h1D
`define IDX_START       8'h40

// ==========================================================
// Field positions
`define MODE_EXPAND     7
`define MODE_PATTERN    6
`define MODE_WIDTH_HI   5
`define MODE_WIDTH_LO   4
`define MODE_TRANSP     3
`define MODE_SYS_SRC    2
`define ST_AUTOSTART    7
`define ST_SRC_LOC      6
`define ST_PAUSE        5
`define ST_ABORT        2
`define ST_LAUNCH       1
`define ST_BUSY         0
`define EXT_SYNC_SWITCH 4
`define EXT_BG_CLIP     3
`define EXT_SOLID       2
`define EXT_INVERT      1
`define EXT_GRAN        0
`define DBUF_EXT_WEN    5
`define DBUF_SEL_HI     2
`define DBUF_SEL_ALL    3'h7
`define WIDTH_8BPP      2'h0
`define REG_RESET       8'h00

// ==========================================================
// Logic function codes
`define LF_ZERO   8'h00
`define LF_NOR    8'h90
`define LF_NSA_D  8'h50
`define LF_NS     8'hD0
`define LF_S_ND   8'h09
`define LF_ND     8'h0B
`define LF_XOR    8'h59
`define LF_NAND   8'hDA
`define LF_AND    8'h05
`define LF_XNOR   8'h95
`define LF_D      8'h06
`define LF_NS_O_D 8'hD6
`define LF_S      8'h0D
`define LF_S_O_ND 8'hAD
`define LF_OR     8'h6D
`define LF_ONE    8'h0E

// ==========================================================
// Source granularity
`define DWORD_BITS      6'h20
`define DWORD_MASK      6'h1F

`endif

// ---- pkg/blit_pkg.sv ----
// Types shared by the blit control block and its surroundings.
// Assumes pixels of at most 16 bits travel one per cycle.
package blit_pkg;

    // ==========================================================
    // Pixel stream carriers and engine state
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] pat;
        logic [15:0] dst;
        logic        mono;
        logic        clip;
        logic        line_end;
        logic [4:0]  line_bit_pos;
        logic        last;
    } pix_in_t;

    typedef struct packed {
        logic [15:0] data;
        logic        write;
        logic        valid;
    } pix_out_t;

    typedef enum logic [0:0] {
        ENG_IDLE,
        ENG_RUN
    } eng_state_t;

endpackage : blit_pkg

// ---- tb/blit_host_model.sv ----
// Host model: hands one source pixel per call over the valid/ready stream.
// Assumes calls start at a falling clock edge; ready is a settled level there.
`timescale 1ns/10ps

module blit_host_model (
    input  wire logic         clk_in,
    input  wire logic         ready_in,
    output blit_pkg::pix_in_t pix_out,
    output logic              valid_out
);
    import blit_pkg::*;

    initial begin
        pix_out   = '0;
        valid_out = 1'b0;
    end

    // ==========================================================
    // Pixel hand-off
    task automatic send(input pix_in_t p, input int gap, output logic ok);
        int n;
        ok = 1'b0;
        repeat (gap) @(negedge clk_in);
        pix_out   = p;
        valid_out = 1'b1;
        // Held until a rising edge sees ready; bounded so a stall cannot hang
        for (n = 0; n < 20 && !ok; n++) begin
            ok = (ready_in === 1'b1);
            @(posedge clk_in);
            if (!ok)
                @(negedge clk_in);
        end
        @(negedge clk_in);
        valid_out = 1'b0;
        // Released lines show the inverse, never a stale copy
        pix_out   = ~p;
    endtask : send
endmodule : blit_host_model

// ---- tb/blit_rop_mode_control_tb_top.sv ----
// Bench for the blit control block: register tasks, one-pixel transfers, checks.
// Assumes display memory cycles are free except in the launch-wait test, and fixed colours.
`timescale 1ns/10ps

module blit_rop_mode_control_tb_top;
    import blit_pkg::*;

    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  idx    = 8'h00;
    logic        wr     = 1'b0;
    logic [7:0]  wdata  = 8'h00;
    logic [7:0]  rdata;
    logic        ready;
    logic        valid;
    logic        busy;
    logic        dvalid;
    logic [5:0]  dbits;
    logic [23:0] dstart;
    logic [7:0]  dbuf   = 8'h27;
    logic        mfree  = 1'b1;
    pix_in_t     pin;
    pix_out_t    pout;
    int          bad_count = 0;
    int          checks    = 0;
    logic [7:0]  codes [16] = '{8'h00, 8'h90, 8'h50, 8'hD0, 8'h09, 8'h0B, 8'h59, 8'hDA,
                                8'h05, 8'h95, 8'h06, 8'hD6, 8'h0D, 8'hAD, 8'h6D, 8'h0E};
    logic [7:0]  ri [5] = '{8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h40};
    logic [7:0]  dm [5] = '{8'h04, 8'h04, 8'h84, 8'h84, 8'h84};
    logic [7:0]  de [5] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
    logic [4:0]  dp [5] = '{5'd13, 5'd5, 5'd13, 5'd13, 5'd0};
    logic [5:0]  dx [5] = '{6'h13, 6'h1B, 6'h03, 6'h13, 6'h00};
    int          tt [3] = '{8, 14, 6};

    always #5 clk_in = ~clk_in;

    blit_rop_mode_control u_dut (
        .clk_in            (clk_in),
        .rst_in            (rst_in),
        .reg_index_in      (idx),
        .reg_wr_in         (wr),
        .reg_wdata_in      (wdata),
        .reg_rdata_out     (rdata),
        .dbuf_ctrl_in      (dbuf),
        .screen_start_in   (24'hABCDE0),
        .mem_cycle_free_in (mfree),
        .fg_color_in       (16'hAAAA),
        .bg_color_in       (16'h5555),
        .pix_in            (pin),
        .pix_valid_in      (valid),
        .pix_ready_out     (ready),
        .pix_out           (pout),
        .discard_bits_out  (dbits),
        .discard_valid_out (dvalid),
        .display_start_out (dstart),
        .busy_out          (busy)
    );

    blit_host_model u_host (
        .clk_in    (clk_in),
        .ready_in  (ready),
        .pix_out   (pin),
        .valid_out (valid)
    );

    // ==========================================================
    // Checking and register access
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        idx   = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk_in);
        wr    = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(negedge clk_in);
        idx = a;
        @(negedge clk_in);
        chk("reg_rdata_out", {16'h0000, e}, {16'h0000, rdata & m});
    endtask : rd_reg

    // Extension writes need autostart stored first
    task automatic set_ext(input logic [7:0] v);
        wr_reg(8'h40, 8'h80);
        wr_reg(8'h1B, v);
    endtask : set_ext

    function automatic logic [15:0] lf_eval(input logic [3:0] t, input logic [15:0] s,
                                            input logic [15:0] d);
        for (int b = 0; b < 16; b++)
            lf_eval[b] = t[{s[b], d[b]}];
    endfunction : lf_eval

    // ==========================================================
    // One-pixel transfer; dd of 3F means no discard pulse expected
    task automatic xfer(input logic [15:0] s, input logic m, input logic c, input logic [4:0] pos,
                        input logic [15:0] ed, input logic ew, input logic [5:0] dd);
        pix_in_t p;
        logic    ok;
        int      n;
        p = '{src: s, pat: ~s, dst: 16'hCCCC, mono: m, clip: c, line_end: 1'b1,
              line_bit_pos: pos, last: 1'b1};
        wr_reg(8'h40, 8'h02);
        for (n = 0; n < 20 && busy !== 1'b1; n++)
            @(negedge clk_in);
        chk("busy_out", 24'h1, {23'h0, busy});
        // Launch never taken: stop here, mismatch already counted
        if (busy !== 1'b1)
            tally_and_finish;
        u_host.send(p, 1, ok);
        chk("pix_ready_out", 24'h1, {23'h0, ok});
        if (ok !== 1'b1)
            tally_and_finish;
        chk("pix_out.valid", 24'h1, {23'h0, pout.valid});
        chk("pix_out.write", {23'h0, ew}, {23'h0, pout.write});
        if (ew)
            chk("pix_out.data", {8'h00, ed}, {8'h00, pout.data});
        chk("busy_out", 24'h0, {23'h0, busy});
        chk("discard_valid_out", {23'h0, dd != 6'h3F}, {23'h0, dvalid});
        if (dd != 6'h3F)
            chk("discard_bits_out", {18'h0, dd}, {18'h0, dbits});
    endtask : xfer

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        for (int i = 0; i < 5; i++)
            rd_reg(ri[i], 8'h00, 8'hFF);
        wr_reg(8'h55, 8'hFF);
        rd_reg(8'h55, 8'h00, 8'hFF);
        wr_reg(8'h1B, 8'h1F);
        rd_reg(8'h1B, 8'h00, 8'hFF);
        set_ext(8'hFF);
        rd_reg(8'h1B, 8'h1F, 8'hFF);
        dbuf = 8'h07;
        set_ext(8'h00);
        rd_reg(8'h1B, 8'h1F, 8'hFF);
        dbuf = 8'h27;
        set_ext(8'h00);
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h1A, codes[i]);
            xfer(16'hF0F0, 1'b0, 1'b0, 5'd0, lf_eval(i[3:0], 16'hF0F0, 16'hCCCC), 1'b1, 6'h3F);
            rd_reg(8'h40, 8'h00, 8'h03);
        end
        wr_reg(8'h18, 8'h40);
        for (int k = 0; k < 3; k++) begin
            wr_reg(8'h1A, codes[tt[k]]);
            xfer(16'h0F0F, 1'b0, 1'b0, 5'd0, lf_eval(tt[k][3:0], 16'hF0F0, 16'hCCCC), 1'b1, 6'h3F);
        end
        // Key compare at 16 bpp, then 8 bpp
        wr_reg(8'h18, 8'h18);
        wr_reg(8'h1C, 8'h34);
        wr_reg(8'h1D, 8'h12);
        wr_reg(8'h1A, 8'h0D);
        xfer(16'h1234, 1'b0, 1'b0, 5'd0, 16'h0000, 1'b0, 6'h3F);
        xfer(16'h3412, 1'b0, 1'b0, 5'd0, 16'h3412, 1'b1, 6'h3F);
        wr_reg(8'h1D, 8'h34);
        wr_reg(8'h18, 8'h08);
        xfer(16'h5634, 1'b0, 1'b0, 5'd0, 16'h0000, 1'b0, 6'h3F);
        xfer(16'h3456, 1'b0, 1'b0, 5'd0, 16'h3456, 1'b1, 6'h3F);
        wr_reg(8'h18, 8'h80);
        xfer(16'h0000, 1'b1, 1'b0, 5'd0, 16'hAAAA, 1'b1, 6'h3F);
        xfer(16'h0000, 1'b0, 1'b0, 5'd0, 16'h5555, 1'b1, 6'h3F);
        wr_reg(8'h18, 8'h88);
        xfer(16'h0000, 1'b0, 1'b0, 5'd0, 16'h0000, 1'b0, 6'h3F);
        set_ext(8'h02);
        xfer(16'h0000, 1'b1, 1'b0, 5'd0, 16'h0000, 1'b0, 6'h3F);
        xfer(16'h0000, 1'b0, 1'b0, 5'd0, 16'hAAAA, 1'b1, 6'h3F);
        set_ext(8'h08);
        wr_reg(8'h18, 8'h80);
        xfer(16'h0000, 1'b1, 1'b1, 5'd0, 16'hAAAA, 1'b1, 6'h3F);
        xfer(16'h0000, 1'b0, 1'b1, 5'd0, 16'h0000, 1'b0, 6'h3F);
        set_ext(8'h00);
        xfer(16'h0000, 1'b1, 1'b1, 5'd0, 16'h0000, 1'b0, 6'h3F);
        set_ext(8'h04);
        wr_reg(8'h18, 8'hC0);
        xfer(16'h0000, 1'b0, 1'b0, 5'd0, 16'hAAAA, 1'b1, 6'h3F);
        // Line-end discard in dword and byte modes
        // line bit positions 13, 5, 13, 13 and 0
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h18, dm[i]);
            set_ext(de[i]);
            xfer(16'hAAAA, 1'b1, 1'b0, dp[i], 16'hAAAA, 1'b1, dx[i]);
        end
        wr_reg(8'h18, 8'h00);
        set_ext(8'h10);
        chk("display_start_out", 24'h000000, dstart);
        xfer(16'h0001, 1'b0, 1'b0, 5'd0, 16'h0001, 1'b1, 6'h3F);
        chk("display_start_out", 24'hABCDE0, dstart);
        xfer(16'h0002, 1'b0, 1'b0, 5'd0, 16'h0002, 1'b1, 6'h3F);
        chk("display_start_out", 24'h000000, dstart);
        // Launch waits for a free memory cycle, then abort in mid-transfer
        mfree = 1'b0;
        wr_reg(8'h40, 8'h02);
        rd_reg(8'h40, 8'h02, 8'h03);
        chk("busy_out", 24'h0, {23'h0, busy});
        mfree = 1'b1;
        @(negedge clk_in);
        chk("busy_out", 24'h1, {23'h0, busy});
        wr_reg(8'h40, 8'h04);
        chk("busy_out", 24'h0, {23'h0, busy});
        rd_reg(8'h40, 8'h00, 8'h03);
        tally_and_finish;
    end
endmodule : blit_rop_mode_control_tb_top
